// File: rtl/flsx_pkg.sv
// Package for the flag and load/store execution block.
// Assumes one clock domain; memories sit outside the block.
`default_nettype none
package flsx_pkg;
  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET  = 8'h00;
  // Pointer pair base registers
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [4:0] REG_ZERO = 5'h00;
  // Cycle counts
  localparam logic [1:0] DATA_CYCLES = 2'h2;
  localparam logic [1:0] PROG_CYCLES = 2'h3;

  // Decoded operations
  typedef enum logic [3:0] {
    FLSX_OP_NOP    = 4'h0,
    FLSX_OP_FSET   = 4'h1,
    FLSX_OP_FCLR   = 4'h2,
    FLSX_OP_MOV    = 4'h3,
    FLSX_OP_REGISTER_PAIR_COPY   = 4'h4,
    FLSX_OP_LDI    = 4'h5,
    FLSX_OP_LD     = 4'h6,
    FLSX_OP_ST     = 4'h7,
    FLSX_OP_LDDIR  = 4'h8,
    FLSX_OP_STDIR  = 4'h9,
    FLSX_OP_PLOAD  = 4'hA,
    FLSX_OP_EPLOAD = 4'hB
  } flsx_op_t;

  // Indirect addressing modes
  typedef enum logic [1:0] {
    FLSX_AM_PLAIN = 2'h0,
    FLSX_AM_POSTI = 2'h1,
    FLSX_AM_PRED  = 2'h2,
    FLSX_AM_DISP  = 2'h3
  } flsx_am_t;

  // One decoded instruction
  typedef struct packed {
    flsx_op_t    op;
    flsx_am_t    mode;
    logic [1:0]  ptr;   // 0 = first, 1 = second, 2 = third pair
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [2:0]  flag;
    logic [5:0]  disp;
    logic [7:0]  imm;
    logic [15:0] addr;
    logic        post_inc;
  } flsx_instr_t;

  // Data memory request
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } flsx_dmem_t;

  typedef enum logic [1:0] {
    FLSX_ST_IDLE = 2'h0,
    FLSX_ST_MEM  = 2'h1,
    FLSX_ST_PROG = 2'h2
  } flsx_state_t;
endpackage
`default_nettype wire

// File: rtl/flsx_core.sv
// Execution core for flag, move and load/store instructions.
// Assumes decoded instructions, data memory answering in the read-strobe cycle and program memory one cycle after a read.
// Functional notes
// [RULE_01] A flag-set instruction raises exactly one flag in one cycle.
// [RULE_02] A flag-clear instruction lowers exactly one flag in one cycle.
// [RULE_03] Post-increment load reads at the pointer then bumps it, two cycles, no flags.
// [RULE_04] Pre-decrement load drops the pointer then reads there, two cycles, no flags.
// [RULE_05] Displacement load reads at any of the three pointers plus offset, pointer kept.
// [RULE_06] Post-increment store writes at the pointer then bumps it, two cycles.
// [RULE_07] Pre-decrement store drops the pointer then writes there, two cycles.
// [RULE_08] Displacement store writes at pointer plus offset, pointer kept, two cycles.
// [RULE_09] Direct load reads the address carried in the instruction, two cycles.
// [RULE_10] Direct store writes to the address carried in the instruction, two cycles.
// [RULE_11] Program load fetches the byte at the third pointer, optional bump, three cycles.
// [RULE_12] Extended program load fetches into the destination in three cycles.
// [RULE_13] Extended program address puts the page select above the third pointer.
// [RULE_14] Moves, pair copies and immediates write in one cycle, no flags, no memory.
`default_nettype none
module flsx_core
  import flsx_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire logic                  instr_valid,
  input  wire flsx_pkg::flsx_instr_t instr,
  output logic                       instr_ready,
  output flsx_pkg::flsx_dmem_t       dmem,
  input  wire logic [7:0]            dmem_rdata,
  output logic                       pmem_rd_en,
  output logic [23:0]                pmem_addr,
  input  wire logic [7:0]            pmem_rdata,
  input  wire logic                  page_wr_en,
  input  wire logic [7:0]            page_wdata,
  output logic [7:0]                 program_page_select,
  output logic [7:0]                 status_flags_register,
  input  wire logic [4:0]            dbg_reg_sel,
  output logic [7:0]                 dbg_reg_data
);
  import flsx_pkg::*;

  logic [7:0]   regs [32];
  logic [7:0]   next_regs [32];
  logic [7:0]   flags, next_flags;
  logic [7:0]   page, next_page;
  flsx_state_t  state, next_state;
  logic [1:0]   cnt, next_cnt;
  logic [4:0]   dest, next_dest;
  flsx_dmem_t   dreq, next_dreq;
  logic         prd, next_prd;
  logic [23:0]  paddr, next_paddr;
  logic [7:0]   dbg, next_dbg;

  // Base register of a pointer pair
  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    unique case (sel)
      2'h0:    ptr_base = PTR_X_LO;
      2'h1:    ptr_base = PTR_Y_LO;
      default: ptr_base = PTR_Z_LO;
    endcase
  endfunction

  // Sixteen-bit value of a pointer pair
  function automatic logic [15:0] ptr_val(input logic [1:0] sel);
    logic [4:0] b;
    b = ptr_base(sel);
    ptr_val = {regs[b + 5'h01], regs[b]};
  endfunction

  assign instr_ready           = (state == FLSX_ST_IDLE);
  assign dmem                  = dreq;
  assign pmem_rd_en            = prd;
  assign pmem_addr             = paddr;
  assign program_page_select   = page;
  assign status_flags_register = flags;
  assign dbg_reg_data          = dbg;

  // Next-state logic for the whole execution path
  always_comb
  begin
    logic [15:0] p;
    logic [15:0] np;
    logic [15:0] ea;
    logic [4:0]  b;
    p  = 16'h0000;
    np = 16'h0000;
    ea = 16'h0000;
    b  = 5'h00;
    for (int i = 0; i < 32; i++)
      next_regs[i] = regs[i];
    next_flags = flags;
    next_page  = page;
    next_state = state;
    next_cnt   = cnt;
    next_dest  = dest;
    next_dreq  = '0;
    next_prd   = 1'b0;
    next_paddr = paddr;
    next_dbg   = regs[dbg_reg_sel];
    if (page_wr_en)
      next_page = page_wdata;
    unique case (state)
      FLSX_ST_IDLE:
      begin
        if (instr_valid)
        begin
          b  = ptr_base(instr.ptr);
          p  = ptr_val(instr.ptr);
          np = p;
          ea = p;
          if (instr.mode == FLSX_AM_POSTI)
            np = p + 16'h0001; // [RULE_03] [RULE_06]
          else if (instr.mode == FLSX_AM_PRED)
          begin
            np = p - 16'h0001; // [RULE_04] [RULE_07]
            ea = np;
          end
          else if (instr.mode == FLSX_AM_DISP)
            ea = p + {10'h000, instr.disp}; // [RULE_05] [RULE_08]
          unique case (instr.op)
            FLSX_OP_FSET:
              next_flags[instr.flag] = 1'b1; // [RULE_01]
            FLSX_OP_FCLR:
              next_flags[instr.flag] = 1'b0; // [RULE_02]
            FLSX_OP_MOV:
              next_regs[instr.rd] = regs[instr.rr]; // [RULE_14]
            FLSX_OP_REGISTER_PAIR_COPY:
            begin
              next_regs[{instr.rd[4:1], 1'b0}] = regs[{instr.rr[4:1], 1'b0}]; // [RULE_14]
              next_regs[{instr.rd[4:1], 1'b1}] = regs[{instr.rr[4:1], 1'b1}];
            end
            FLSX_OP_LDI:
              next_regs[instr.rd] = instr.imm; // [RULE_14]
            FLSX_OP_LD, FLSX_OP_ST, FLSX_OP_LDDIR, FLSX_OP_STDIR:
            begin
              // Pointer update happens in the request cycle; address uses old/new as needed
              if (instr.op == FLSX_OP_LD || instr.op == FLSX_OP_ST)
              begin
                next_regs[b]         = np[7:0];
                next_regs[b + 5'h01] = np[15:8];
              end
              else
                ea = instr.addr; // [RULE_09] [RULE_10]
              next_dreq.addr  = ea;
              next_dreq.rd_en = (instr.op == FLSX_OP_LD || instr.op == FLSX_OP_LDDIR);
              next_dreq.wr_en = (instr.op == FLSX_OP_ST || instr.op == FLSX_OP_STDIR);
              next_dreq.wdata = regs[instr.rr];
              next_dest  = instr.rd;
              next_cnt   = DATA_CYCLES - 2'h1;
              next_state = FLSX_ST_MEM;
            end
            FLSX_OP_PLOAD, FLSX_OP_EPLOAD:
            begin
              p = ptr_val(2'h2);
              if (instr.op == FLSX_OP_EPLOAD)
                next_paddr = {page, p}; // [RULE_13]
              else
                next_paddr = {8'h00, p}; // [RULE_11]
              if (instr.post_inc)
              begin
                np = p + 16'h0001; // [RULE_11]
                next_regs[PTR_Z_LO]         = np[7:0];
                next_regs[PTR_Z_LO + 5'h01] = np[15:8];
              end
              next_prd   = 1'b1;
              next_dest  = instr.rd;
              next_cnt   = PROG_CYCLES - 2'h1;
              next_state = FLSX_ST_PROG;
            end
            default:
              ;
          endcase
        end
      end
      FLSX_ST_MEM:
      begin
        // Second cycle: read data returns, store already issued
        if (dreq.rd_en)
          next_regs[dest] = dmem_rdata; // [RULE_03] [RULE_04] [RULE_05] [RULE_09]
        next_state = FLSX_ST_IDLE; // [RULE_06] [RULE_07] [RULE_08] [RULE_10]
      end
      FLSX_ST_PROG:
      begin
        // Program memory is slower: one wait, then capture
        next_cnt = cnt - 2'h1;
        if (cnt == 2'h1)
        begin
          next_regs[dest] = pmem_rdata; // [RULE_11] [RULE_12]
          next_state = FLSX_ST_IDLE;
        end
      end
      default:
        next_state = FLSX_ST_IDLE;
    endcase
  end

  // State registers; clock enable freezes everything
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
        regs[i] <= 8'h00;
      flags <= FLAGS_RESET;
      page  <= PAGE_RESET;
      state <= FLSX_ST_IDLE;
      cnt   <= 2'h0;
      dest  <= 5'h00;
      dreq  <= '0;
      prd   <= 1'b0;
      paddr <= 24'h000000;
      dbg   <= 8'h00;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < 32; i++)
        regs[i] <= next_regs[i];
      flags <= next_flags;
      page  <= next_page;
      state <= next_state;
      cnt   <= next_cnt;
      dest  <= next_dest;
      dreq  <= next_dreq;
      prd   <= next_prd;
      paddr <= next_paddr;
      dbg   <= next_dbg;
    end
  end

  // Flag set changes only the chosen bit
  a_flag_set_one: assert property (@(posedge clock) disable iff (rst) // [RULE_01]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_FSET |=>
      flags[$past(instr.flag)] && ((flags ^ $past(flags)) & ~(8'h01 << $past(instr.flag))) == 8'h00)
    else $error("flag set touched other bits");

  a_flag_clr_one: assert property (@(posedge clock) disable iff (rst) // [RULE_02]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_FCLR |=>
      !flags[$past(instr.flag)] && ((flags ^ $past(flags)) & ~(8'h01 << $past(instr.flag))) == 8'h00)
    else $error("flag clear touched other bits");

  a_data_two_cyc: assert property (@(posedge clock) disable iff (rst) // [RULE_03]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_LD ##1 clk_en |=>
      instr_ready)
    else $error("data load not two cycles");

  a_ld_no_flags: assert property (@(posedge clock) disable iff (rst) // [RULE_04]
    state == FLSX_ST_MEM |-> flags == $past(flags))
    else $error("memory access changed flags");

  a_disp_keep_ptr: assert property (@(posedge clock) disable iff (rst) // [RULE_05]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_LD &&
      instr.mode == FLSX_AM_DISP |=> dreq.rd_en &&
      dreq.addr == $past(ptr_val(instr.ptr)) + {10'h000, $past(instr.disp)} &&
      ptr_val($past(instr.ptr)) == $past(ptr_val(instr.ptr)))
    else $error("displacement moved pointer");

  a_store_issued: assert property (@(posedge clock) disable iff (rst) // [RULE_10]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_STDIR |=>
      dreq.wr_en && dreq.addr == $past(instr.addr))
    else $error("direct store address wrong");

  a_prog_three: assert property (@(posedge clock) disable iff (rst) // [RULE_11]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_PLOAD ##1 clk_en ##1 clk_en
      |=> instr_ready)
    else $error("program load not three cycles");

  a_ext_page_addr: assert property (@(posedge clock) disable iff (rst) // [RULE_13]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_EPLOAD |=>
      pmem_addr[23:16] == $past(page))
    else $error("page select not on address");

  a_move_one_cyc: assert property (@(posedge clock) disable iff (rst) // [RULE_14]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_LDI |=>
      instr_ready && !dreq.wr_en && regs[$past(instr.rd)] == $past(instr.imm))
    else $error("immediate load wrong");

  // Request-cycle address and pointer checks; the pointer moves before data returns
  a_posti_ld_addr: assert property (@(posedge clock) disable iff (rst) // [RULE_03]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_LD &&
      instr.mode == FLSX_AM_POSTI |=> dreq.rd_en &&
      dreq.addr == $past(ptr_val(instr.ptr)) &&
      ptr_val($past(instr.ptr)) == $past(ptr_val(instr.ptr)) + 16'h0001)
    else $error("post-increment load address wrong");

  a_pred_ld_addr: assert property (@(posedge clock) disable iff (rst) // [RULE_04]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_LD &&
      instr.mode == FLSX_AM_PRED |=> dreq.rd_en &&
      dreq.addr == $past(ptr_val(instr.ptr)) - 16'h0001 &&
      ptr_val($past(instr.ptr)) == dreq.addr)
    else $error("pre-decrement load address wrong");

  a_posti_st_addr: assert property (@(posedge clock) disable iff (rst) // [RULE_06]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_ST &&
      instr.mode == FLSX_AM_POSTI |=> dreq.wr_en &&
      dreq.addr == $past(ptr_val(instr.ptr)) &&
      ptr_val($past(instr.ptr)) == $past(ptr_val(instr.ptr)) + 16'h0001)
    else $error("post-increment store address wrong");

  a_pred_st_addr: assert property (@(posedge clock) disable iff (rst) // [RULE_07]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_ST &&
      instr.mode == FLSX_AM_PRED |=> dreq.wr_en &&
      dreq.addr == $past(ptr_val(instr.ptr)) - 16'h0001 &&
      ptr_val($past(instr.ptr)) == dreq.addr)
    else $error("pre-decrement store address wrong");

  a_disp_st_addr: assert property (@(posedge clock) disable iff (rst) // [RULE_08]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_ST &&
      instr.mode == FLSX_AM_DISP |=> dreq.wr_en &&
      dreq.addr == $past(ptr_val(instr.ptr)) + {10'h000, $past(instr.disp)} &&
      ptr_val($past(instr.ptr)) == $past(ptr_val(instr.ptr)))
    else $error("displacement store address wrong");

  // Read data lands in the destination at the end of the memory cycle
  a_mem_capture: assert property (@(posedge clock) disable iff (rst) // [RULE_09]
    clk_en && state == FLSX_ST_MEM && dreq.rd_en |=> regs[$past(dest)] == $past(dmem_rdata))
    else $error("load data not captured");

  a_prog_capture: assert property (@(posedge clock) disable iff (rst) // [RULE_12]
    clk_en && instr_ready && instr_valid && instr.op == FLSX_OP_EPLOAD ##1 clk_en ##1 clk_en
      |=> instr_ready && regs[$past(instr.rd, 3)] == $past(pmem_rdata))
    else $error("extended program byte not captured");
endmodule
`default_nettype wire

// File: verification/flsx_mem_model.sv
// Data and program memory model facing the flag/load-store core.
// Assumes registered requests on one clock; only 256 data bytes.
`default_nettype none
module flsx_mem_model
  import flsx_pkg::*;
(
  input  wire logic                 clock,
  input  wire flsx_pkg::flsx_dmem_t dmem,
  output logic [7:0]                dmem_rdata,
  input  wire logic                 pmem_rd_en,
  input  wire logic [23:0]          pmem_addr,
  output logic [7:0]                pmem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] dmem_q [256];
  logic [7:0] held;
  logic       held_ok;
  logic       prog_ok;
  logic [7:0] image;

  // Data lives three cycles, then toggles so a late sample is caught
  always_ff @(posedge clock)
  begin
    held_ok <= dmem.rd_en;
    prog_ok <= pmem_rd_en;
    held    <= dmem.rd_en ? dmem_q[dmem.addr[7:0]] : ~held;
    if (dmem.wr_en)
      dmem_q[dmem.addr[7:0]] <= dmem.wdata;
  end
  assign dmem_rdata = dmem.rd_en ? dmem_q[dmem.addr[7:0]] : (held_ok ? held : ~held);
  // Program image derived from the address, page byte included
  assign image      = pmem_addr[7:0] ^ pmem_addr[23:16] ^ 8'h5A;
  assign pmem_rdata = (pmem_rd_en | prog_ok) ? image : ~image;
endmodule
`default_nettype wire

// File: verification/flsx_core_test.sv
// Self-checking bench for the flag and load/store core.
// Assumes flsx_mem_model answers on the far side.
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module flsx_core_test;
  import flsx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, clk_en = 1, instr_valid = 0, page_wr_en = 0;
  logic [7:0] page_wdata = 8'h00;
  logic [4:0] dbg_reg_sel = 5'h00;
  flsx_instr_t instr = '0;
  flsx_dmem_t dmem;
  logic instr_ready, pmem_rd_en;
  logic [7:0] dmem_rdata, pmem_rdata, program_page_select, status_flags_register, dbg_reg_data;
  logic [23:0] pmem_addr;
  int mismatches = 0, checks_done = 0;

  flsx_core dut (.clock(clock), .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .dmem(dmem), .dmem_rdata(dmem_rdata),
    .pmem_rd_en(pmem_rd_en), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .page_wr_en(page_wr_en), .page_wdata(page_wdata),
    .program_page_select(program_page_select),
    .status_flags_register(status_flags_register), .dbg_reg_sel(dbg_reg_sel),
    .dbg_reg_data(dbg_reg_data));
  flsx_mem_model mem (.clock(clock), .dmem(dmem), .dmem_rdata(dmem_rdata),
    .pmem_rd_en(pmem_rd_en), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));

  initial
  begin
    forever #4 clock = ~clock;
  end

  function automatic flsx_instr_t mi(flsx_op_t o, flsx_am_t m, logic [1:0] p,
    logic [4:0] d, logic [4:0] r, logic [7:0] k, logic [15:0] a);
    flsx_instr_t t;
    t = '0;
    t.op = o; t.mode = m; t.ptr = p; t.rd = d; t.rr = r; t.flag = k[2:0];
    t.imm = k; t.addr = a; t.disp = a[5:0]; t.post_inc = (m == FLSX_AM_POSTI);
    return t;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Issue one instruction; the edges until ready returns give its length
  task automatic go(flsx_instr_t t, int exp_n);
    int n;
    n = 0;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= t;
    @(posedge clock);
    instr_valid <= 1'b0;
    n = 1;
    #1;
    while (instr_ready !== 1'b1 && n < 8)
    begin
      @(posedge clock);
      n++;
      #1;
    end
    if (n >= 8)
    begin
      mismatches++;
      stop_test();
    end
    else
      `CHK("cycles", exp_n, n)
  endtask

  // Register readback through the one-cycle debug port
  task automatic getr(logic [4:0] s, output logic [7:0] v);
    @(posedge clock);
    dbg_reg_sel <= s;
    repeat (2) @(posedge clock);
    #1 v = dbg_reg_data;
  endtask

  task automatic t_flags();
    logic [7:0] e;
    e = 8'h00;
    for (int b = 1; b < 8; b++)
    begin
      e[b] = 1'b1;
      go(mi(FLSX_OP_FSET, FLSX_AM_PLAIN, 2'h0, 5'h00, 5'h00, 8'(b), 16'h0000), 1);
      `CHK("set flags", e, status_flags_register)
    end
    for (int b = 1; b < 8; b++)
    begin
      e[b] = 1'b0;
      go(mi(FLSX_OP_FCLR, FLSX_AM_PLAIN, 2'h0, 5'h00, 5'h00, 8'(b), 16'h0000), 1);
      `CHK("clear flags", e, status_flags_register)
    end
    go(mi(FLSX_OP_FSET, FLSX_AM_PLAIN, 2'h0, 5'h00, 5'h00, 8'(FLAG_I), 16'h0000), 1);
    $display("test flags done");
  endtask

  task automatic t_moves();
    logic [4:0] r [8] = '{5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h10, 5'h11};
    logic [7:0] k [8] = '{8'h10, 8'h00, 8'h20, 8'h00, 8'h80, 8'h00, 8'hA5, 8'h3C};
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
      go(mi(FLSX_OP_LDI, FLSX_AM_PLAIN, 2'h0, r[i], 5'h00, k[i], 16'h0000), 1);
    go(mi(FLSX_OP_MOV, FLSX_AM_PLAIN, 2'h0, 5'h12, 5'h10, 8'h00, 16'h0000), 1);
    go(mi(FLSX_OP_REGISTER_PAIR_COPY, FLSX_AM_PLAIN, 2'h0, 5'h14, 5'h10, 8'h00, 16'h0000), 1);
    getr(5'h12, v); `CHK("mov", 8'hA5, v)
    getr(5'h15, v); `CHK("pair copy", 8'h3C, v)
    $display("test moves done");
  endtask

  task automatic t_data();
    logic [7:0] v;
    go(mi(FLSX_OP_ST, FLSX_AM_POSTI, 2'h0, 5'h00, 5'h10, 8'h00, 16'h0000), 2);
    go(mi(FLSX_OP_ST, FLSX_AM_PRED, 2'h1, 5'h00, 5'h11, 8'h00, 16'h0000), 2);
    go(mi(FLSX_OP_ST, FLSX_AM_DISP, 2'h2, 5'h00, 5'h10, 8'h00, 16'h003F), 2);
    go(mi(FLSX_OP_STDIR, FLSX_AM_PLAIN, 2'h0, 5'h00, 5'h11, 8'h00, 16'h0040), 2);
    `CHK("st x+", 8'hA5, mem.dmem_q[8'h10])
    `CHK("st -y", 8'h3C, mem.dmem_q[8'h1F])
    `CHK("st z+q", 8'hA5, mem.dmem_q[8'hBF])
    `CHK("st direct", 8'h3C, mem.dmem_q[8'h40])
    getr(5'h1A, v); `CHK("x after st", 8'h11, v)
    getr(5'h1C, v); `CHK("y after st", 8'h1F, v)
    getr(5'h1E, v); `CHK("z kept", 8'h80, v)
    go(mi(FLSX_OP_LD, FLSX_AM_PRED, 2'h0, 5'h01, 5'h00, 8'h00, 16'h0000), 2);
    go(mi(FLSX_OP_LD, FLSX_AM_POSTI, 2'h1, 5'h02, 5'h00, 8'h00, 16'h0000), 2);
    go(mi(FLSX_OP_LD, FLSX_AM_DISP, 2'h1, 5'h03, 5'h00, 8'h00, 16'h0020), 2);
    go(mi(FLSX_OP_LDDIR, FLSX_AM_PLAIN, 2'h0, 5'h04, 5'h00, 8'h00, 16'h00BF), 2);
    getr(5'h01, v); `CHK("ld -x", 8'hA5, v)
    getr(5'h1A, v); `CHK("x after ld", 8'h10, v)
    getr(5'h02, v); `CHK("ld y+", 8'h3C, v)
    getr(5'h1C, v); `CHK("y after ld", 8'h20, v)
    getr(5'h03, v); `CHK("ld y+q", 8'h3C, v)
    getr(5'h04, v); `CHK("ld direct", 8'hA5, v)
    `CHK("flags kept", 8'h80, status_flags_register)
    $display("test data done");
  endtask

  // Clock enable low: a clear is refused and a load parks in its memory cycle
  task automatic t_hold();
    logic [7:0] v;
    @(posedge clock);
    clk_en <= 1'b0;
    instr_valid <= 1'b1;
    instr <= mi(FLSX_OP_FCLR, FLSX_AM_PLAIN, 2'h0, 5'h00, 5'h00, 8'(FLAG_I), 16'h0000);
    repeat (3) @(posedge clock);
    instr <= mi(FLSX_OP_LD, FLSX_AM_POSTI, 2'h0, 5'h07, 5'h00, 8'h00, 16'h0000);
    clk_en <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    clk_en <= 1'b0;
    #1;
    `CHK("frozen flags", 8'h80, status_flags_register)
    `CHK("ready while frozen", 1'b0, instr_ready)
    repeat (3) @(posedge clock);
    #1;
    `CHK("ready still frozen", 1'b0, instr_ready)
    `CHK("held read strobe", 1'b1, dmem.rd_en)
    @(posedge clock);
    clk_en <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("ready after thaw", 1'b1, instr_ready)
    getr(5'h07, v); `CHK("frozen load", 8'hA5, v)
    getr(5'h1A, v); `CHK("x after frozen load", 8'h11, v)
    $display("test hold done");
  endtask

  task automatic t_prog();
    logic [7:0] v;
    @(posedge clock);
    page_wr_en <= 1'b1;
    page_wdata <= 8'h03;
    @(posedge clock);
    page_wr_en <= 1'b0;
    go(mi(FLSX_OP_PLOAD, FLSX_AM_PLAIN, 2'h2, REG_ZERO, 5'h00, 8'h00, 16'h0000), 3);
    go(mi(FLSX_OP_PLOAD, FLSX_AM_POSTI, 2'h2, 5'h05, 5'h00, 8'h00, 16'h0000), 3);
    go(mi(FLSX_OP_EPLOAD, FLSX_AM_PLAIN, 2'h2, 5'h06, 5'h00, 8'h00, 16'h0000), 3);
    `CHK("page", 8'h03, program_page_select)
    getr(REG_ZERO, v); `CHK("pload r0", 8'hDA, v)
    getr(5'h05, v); `CHK("pload z+", 8'hDA, v)
    getr(5'h1E, v); `CHK("z after pload", 8'h81, v)
    getr(5'h06, v); `CHK("extended pload", 8'hD8, v)
    `CHK("flags kept", 8'h80, status_flags_register)
    $display("test prog done");
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_flags();
    t_moves();
    t_data();
    t_hold();
    t_prog();
    stop_test();
  end
endmodule
`default_nettype wire
